// ### usm_regs.vh
// Register offsets, field positions, reset values and size constants of the USART master serial block.
`ifndef USM_REGS_VH
`define USM_REGS_VH
`define USM_ADDR_STATUS_A 8'hC0
`define USM_ADDR_CTRL_B 8'hC1
`define USM_ADDR_CTRL_C 8'hC2
`define USM_ADDR_BAUD_LO 8'hC4
`define USM_ADDR_BAUD_HI 8'hC5
`define USM_ADDR_DATA 8'hC6
`define USM_RST_CTRL_C 8'h06
`define USM_RST_BAUD 12'h000
`define USM_RST_STATUS_A 8'h20
`define USM_BIT_RXC 7
`define USM_BIT_TXC 6
`define USM_BIT_DRE 5
`define USM_BIT_RXCIE 7
`define USM_BIT_TXCIE 6
`define USM_BIT_DREIE 5
`define USM_BIT_RXEN 4
`define USM_BIT_TXEN 3
`define USM_BIT_ORDER 2
`define USM_BIT_PHASE 1
`define USM_BIT_POL 0
`define USM_MODE_MSB 7
`define USM_MODE_LSB 6
`define USM_MODE_MASTER 2'b11
`define USM_FRAME_BITS 8
`define USM_RXFIFO_DEPTH 2
`endif

// ### usm_rx_store.v
// Two-entry receive buffer with registered read data.
`timescale 1ns/100ps
module usm_rx_store #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Control
	input wire flush,
	// Fill side
	input wire wrValid,
	input wire [WIDTH-1:0] wrData,
	// Drain side
	input wire rdTake,
	output wire notEmpty,
	output reg [WIDTH-1:0] rdData
);
	reg [WIDTH-1:0] mem0;
	reg [WIDTH-1:0] mem1;
	reg [1:0] count_r;
	assign notEmpty = (count_r != 2'd0);
	// ==========================================================
	// Storage
	always @(posedge clk_sys) begin
		if (!nrst || flush) begin
			count_r <= 2'd0;
			mem0 <= {WIDTH{1'b0}};
			mem1 <= {WIDTH{1'b0}};
			rdData <= {WIDTH{1'b0}};
		end else begin
			// The read register always holds the oldest entry, so a read returns it at once.
			case ({rdTake && notEmpty, wrValid})
			2'b01: begin
				// A full buffer drops the newest byte and keeps the older ones.
				if (count_r == 2'd0) begin
					mem0 <= wrData;
					rdData <= wrData;
					count_r <= 2'd1;
				end else if (count_r == 2'd1) begin
					mem1 <= wrData;
					count_r <= 2'd2;
				end
			end
			2'b10: begin
				rdData <= mem1;
				mem0 <= mem1;
				count_r <= count_r - 2'd1;
			end
			2'b11: begin
				if (count_r == 2'd1) begin
					mem0 <= wrData;
					rdData <= wrData;
				end else begin
					mem0 <= mem1;
					mem1 <= wrData;
					rdData <= mem1;
				end
			end
			default: begin
				count_r <= count_r;
			end
			endcase
		end
	end
endmodule // usm_rx_store

// ### usm_master_spi.v
// USART in master serial peripheral mode: registers, baud generator and transfer controller.
`timescale 1ns/100ps
`include "usm_regs.vh"
module usm_master_spi (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Register port
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdata,
	// Serial pins
	input wire serialInPin,
	output reg serialOutPin,
	output wire serialOutOe,
	output reg transferClockPin,
	input wire clockPinDirectionBit,
	output wire transferClockOe,
	// Interrupt requests
	output wire irqRxComplete,
	output wire irqTxComplete,
	output wire irqDataEmpty
);
	localparam ST_IDLE = 2'd0;
	localparam ST_LEAD = 2'd1;
	localparam ST_TRAIL = 2'd2;

	// ==========================================================
	// Registers
	reg [7:0] controlStatusC_r;
	reg [7:0] controlB_r;
	reg [11:0] baudDivisor_r;
	reg txComplete_r;
	reg [7:0] txBuf_r;
	reg txBufFull_r;
	reg [7:0] shiftOut_r;
	reg [7:0] shiftIn_r;
	reg [11:0] baudCnt_r;
	reg [2:0] bitCnt_r;
	reg [1:0] state_r;
	reg inSync1_r;
	reg inSync2_r;
	reg rxPush_r;
	reg [7:0] rxPushData_r;
	reg txEnEff_r;

	wire masterMode = (controlStatusC_r[`USM_MODE_MSB:`USM_MODE_LSB] == `USM_MODE_MASTER);
	wire clockPolarityBit = controlStatusC_r[`USM_BIT_POL];
	wire clockPhaseBit = controlStatusC_r[`USM_BIT_PHASE];
	// These settings are read live, so changing them mid-frame corrupts that frame.
	wire bitOrderSelect = controlStatusC_r[`USM_BIT_ORDER];
	wire transmitterEnableBit = controlB_r[`USM_BIT_TXEN];
	wire receiverEnableBit = controlB_r[`USM_BIT_RXEN];
	wire rxActive = receiverEnableBit && transmitterEnableBit;
	wire busy = (state_r != ST_IDLE);
	wire selStatus = (regAddr == `USM_ADDR_STATUS_A);
	wire selData = (regAddr == `USM_ADDR_DATA);
	wire dataWrite = regWrite && selData;
	wire dataRead = regRead && selData;
	wire txcClear = regWrite && selStatus && regWdata[`USM_BIT_TXC];
	wire txAccept = dataWrite && transmitterEnableBit && masterMode;
	wire baudTick = (baudCnt_r == 12'h000);
	// The last half bit of a frame ends here; the shifter then reloads or stops.
	wire frameEnd = (state_r == ST_TRAIL) && baudTick && (bitCnt_r == 3'd7);
	wire txLoad = txBufFull_r && ((state_r == ST_IDLE) || frameEnd);
	wire rxNotEmpty;
	wire [7:0] rxData;
	wire dataEmpty = !txBufFull_r;

	// Picks the bit to send next for the given order.
	function outBit;
		input [7:0] value;
		input lsbFirst;
		begin
			outBit = lsbFirst ? value[0] : value[7];
		end
	endfunction

	// Shifts one bit in or out toward the side given by the order.
	function [7:0] shiftStep;
		input [7:0] value;
		input lsbFirst;
		input newBit;
		begin
			shiftStep = lsbFirst ? {newBit, value[7:1]} : {value[6:0], newBit};
		end
	endfunction

	// ==========================================================
	// Input synchroniser
	always @(posedge clk_sys) begin
		if (!nrst) begin
			inSync1_r <= 1'b0;
			inSync2_r <= 1'b0;
		end else begin
			inSync1_r <= serialInPin;
			inSync2_r <= inSync1_r;
		end
	end

	// ==========================================================
	// Control registers
	always @(posedge clk_sys) begin
		if (!nrst) begin
			controlStatusC_r <= `USM_RST_CTRL_C;
			controlB_r <= 8'h00;
			baudDivisor_r <= `USM_RST_BAUD;
		end else if (regWrite) begin
			case (regAddr)
			`USM_ADDR_CTRL_B: controlB_r <= regWdata;
			`USM_ADDR_CTRL_C: controlStatusC_r <= regWdata;
			`USM_ADDR_BAUD_LO: baudDivisor_r[7:0] <= regWdata;
			`USM_ADDR_BAUD_HI: baudDivisor_r[11:8] <= regWdata[3:0];
			default: controlB_r <= controlB_r;
			endcase
		end
	end

	// Transmitter stays effective until pending data has been sent.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			txEnEff_r <= 1'b0;
		end else if (transmitterEnableBit) begin
			txEnEff_r <= 1'b1;
		end else if (!busy && !txBufFull_r) begin
			txEnEff_r <= 1'b0;
		end
	end
	assign serialOutOe = txEnEff_r;
	assign transferClockOe = clockPinDirectionBit;

	// ==========================================================
	// Baud generator
	always @(posedge clk_sys) begin
		if (!nrst) begin
			baudCnt_r <= `USM_RST_BAUD;
		end else if (regWrite && regAddr == `USM_ADDR_BAUD_LO) begin
			baudCnt_r <= {baudDivisor_r[11:8], regWdata};
		end else if (baudTick || !busy) begin
			baudCnt_r <= baudDivisor_r;
		end else begin
			baudCnt_r <= baudCnt_r - 12'h001;
		end
	end

	// ==========================================================
	// Transmit buffer
	// A byte may be queued in the same cycle in which the shifter takes the old one.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			txBuf_r <= 8'h00;
			txBufFull_r <= 1'b0;
		end else if (txAccept && (!txBufFull_r || txLoad)) begin
			txBuf_r <= regWdata;
			txBufFull_r <= 1'b1;
		end else if (txLoad) begin
			txBufFull_r <= 1'b0;
		end
	end

	// Software clears the complete flag by writing one; a new set wins.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			txComplete_r <= 1'b0;
		end else if (frameEnd && !txBufFull_r) begin
			txComplete_r <= 1'b1;
		end else if (txcClear) begin
			txComplete_r <= 1'b0;
		end
	end

	// The finished byte enters the receive buffer one cycle after frameEnd, half a bit after its last sample when the phase bit is clear.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			rxPush_r <= 1'b0;
			rxPushData_r <= 8'h00;
		end else begin
			rxPush_r <= frameEnd && rxActive;
			if (frameEnd && clockPhaseBit) begin
				rxPushData_r <= shiftStep(shiftIn_r, bitOrderSelect, inSync2_r);
			end else if (frameEnd) begin
				rxPushData_r <= shiftIn_r;
			end
		end
	end

	// ==========================================================
	// Transfer controller
	always @(posedge clk_sys) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			shiftOut_r <= 8'h00;
			shiftIn_r <= 8'h00;
			bitCnt_r <= 3'd0;
			serialOutPin <= 1'b1;
			transferClockPin <= 1'b0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				transferClockPin <= clockPolarityBit;
				if (txLoad) begin
					shiftOut_r <= txBuf_r;
					bitCnt_r <= 3'd0;
					state_r <= ST_LEAD;
					if (!clockPhaseBit) begin
						serialOutPin <= outBit(txBuf_r, bitOrderSelect);
					end
				end else begin
					serialOutPin <= 1'b1;
				end
			end
			ST_LEAD: begin
				if (baudTick) begin
					transferClockPin <= !clockPolarityBit;
					state_r <= ST_TRAIL;
					if (clockPhaseBit) begin
						serialOutPin <= outBit(shiftOut_r, bitOrderSelect);
					end else begin
						shiftIn_r <= shiftStep(shiftIn_r, bitOrderSelect, inSync2_r);
					end
				end
			end
			ST_TRAIL: begin
				if (baudTick) begin
					transferClockPin <= clockPolarityBit;
					if (clockPhaseBit) begin
						shiftIn_r <= shiftStep(shiftIn_r, bitOrderSelect, inSync2_r);
					end
					if (txLoad) begin
						// Back-to-back frame follows without a gap.
						shiftOut_r <= txBuf_r;
						bitCnt_r <= 3'd0;
						state_r <= ST_LEAD;
						if (!clockPhaseBit) begin
							serialOutPin <= outBit(txBuf_r, bitOrderSelect);
						end
					end else if (frameEnd) begin
						state_r <= ST_IDLE;
					end else begin
						shiftOut_r <= shiftStep(shiftOut_r, bitOrderSelect, 1'b1);
						bitCnt_r <= bitCnt_r + 3'd1;
						state_r <= ST_LEAD;
						if (!clockPhaseBit) begin
							serialOutPin <= outBit(shiftStep(shiftOut_r, bitOrderSelect, 1'b1),
								bitOrderSelect);
						end
					end
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receive buffer
	usm_rx_store #(
		.WIDTH(`USM_FRAME_BITS)
	) rxStore (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.flush(!rxActive),
		.wrValid(rxPush_r),
		.wrData(rxPushData_r),
		.rdTake(dataRead),
		.notEmpty(rxNotEmpty),
		.rdData(rxData)
	);

	// ==========================================================
	// Flags to the shared interrupt logic
	assign irqRxComplete = controlB_r[`USM_BIT_RXCIE] && rxNotEmpty;
	assign irqTxComplete = controlB_r[`USM_BIT_TXCIE] && txComplete_r;
	assign irqDataEmpty = controlB_r[`USM_BIT_DREIE] && dataEmpty;

	// ==========================================================
	// Read path
	// Parity, frame error and overrun bits stay zero in this mode.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
			`USM_ADDR_STATUS_A: regRdata <= {rxNotEmpty, txComplete_r, dataEmpty, 5'b0_0000};
			`USM_ADDR_CTRL_B: regRdata <= controlB_r;
			`USM_ADDR_CTRL_C: regRdata <= controlStatusC_r;
			`USM_ADDR_BAUD_LO: regRdata <= baudDivisor_r[7:0];
			`USM_ADDR_BAUD_HI: regRdata <= {4'h0, baudDivisor_r[11:8]};
			`USM_ADDR_DATA: regRdata <= rxData;
			default: regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

endmodule // usm_master_spi

// ### usm_spi_assertions.sv
// Concurrent checks on the ports of the master serial block.
`timescale 1ns/100ps
`include "usm_regs.vh"
module usm_spi_assertions (
	// Clock, reset and register port
	input wire clk_sys,
	input wire nrst,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regRdata,
	// Pins and requests
	input wire serialOutPin,
	input wire serialOutOe,
	input wire transferClockPin,
	input wire clockPinDirectionBit,
	input wire transferClockOe,
	input wire irqRxComplete,
	input wire irqTxComplete,
	input wire irqDataEmpty
);
	reg [11:0] div_r;
	reg [2:0] ie_r;
	reg [7:0] ctc_r;
	reg [12:0] gap_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Shadow copies of the registers that the relations below depend on.
	always @(posedge clk_sys) begin
		gap_r <= ($changed(transferClockPin) || !nrst) ? 13'h0000 : gap_r + {12'h000, ~&gap_r};
		if (!nrst) begin
			div_r <= 12'h000;
			ie_r <= 3'h0;
			ctc_r <= 8'h06;
		end else if (regWrite) begin
			if (regAddr == `USM_ADDR_BAUD_LO) div_r[7:0] <= regWdata;
			if (regAddr == `USM_ADDR_BAUD_HI) div_r[11:8] <= regWdata[3:0];
			if (regAddr == `USM_ADDR_CTRL_B) ie_r <= regWdata[7:5];
			if (regAddr == `USM_ADDR_CTRL_C) ctc_r <= regWdata;
		end
	end
	a_clk_oe_follow: assert property (transferClockOe == clockPinDirectionBit)
		else $error("clock enable differs from direction");
	a_rdata_idle_zero: assert property (!$past(regRead) |-> regRdata == 8'h00)
		else $error("read data not zero outside read");
	a_reset_idle_pins: assert property (!$past(nrst) |->
		serialOutPin && !serialOutOe && !transferClockPin)
		else $error("pins not idle after reset");
	a_status_err_zero: assert property (regRead && regAddr == `USM_ADDR_STATUS_A |=>
		regRdata[4:2] == 3'h0) else $error("error flags not zero");
	a_baud_hi_read: assert property (regRead && regAddr == `USM_ADDR_BAUD_HI |=>
		regRdata == {4'h0, div_r[11:8]}) else $error("divisor high readback");
	a_half_period_min: assert property ($changed(transferClockPin) && serialOutOe &&
		$past(ctc_r, 2) == ctc_r |->
		gap_r >= {1'b0, div_r}) else $error("clock half period too short");
	a_irq_mask_off: assert property (({irqRxComplete, irqTxComplete, irqDataEmpty} & ~ie_r) == 3'h0)
		else $error("request without enable");
	a_sck_quiet_off: assert property (!serialOutOe && !$past(serialOutOe) &&
		$past(ctc_r, 2) == ctc_r |-> $stable(transferClockPin)) else $error("clock moves while off");
endmodule // usm_spi_assertions
bind usm_master_spi usm_spi_assertions chk (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .transferClockPin(transferClockPin),
	.clockPinDirectionBit(clockPinDirectionBit), .transferClockOe(transferClockOe),
	.irqRxComplete(irqRxComplete), .irqTxComplete(irqTxComplete), .irqDataEmpty(irqDataEmpty));

// ### usm_slave_model.sv
// Serial slave that shifts in MSB first and answers frame n with base plus n.
`timescale 1ns/100ps
module usm_slave_model (
	// Clock and setup
	input wire clk_sys,
	input wire restart,
	input wire cpol,
	input wire cpha,
	input wire [7:0] base,
	// Serial pins
	input wire sck,
	input wire mosi,
	output wire miso,
	// Observation
	output reg [7:0] got,
	output reg [7:0] nFrm = 8'h00
);
	reg prev;
	reg [7:0] sh;
	reg [2:0] sCnt;
	reg [2:0] oCnt = 3'h0;
	wire edgeSeen = sck != prev;
	wire lead = edgeSeen && prev == cpol;
	wire smp = edgeSeen && (lead ^ cpha);
	wire [7:0] outB = base + nFrm;
	// The reply bit moves on setup edges and, as nFrm steps, just after a frame's last sample, so it is steady at each sample edge.
	assign miso = outB[3'h7 - oCnt + {2'h0, cpha}];
	always @(posedge clk_sys) begin
		prev <= sck;
		if (restart) begin
			sCnt <= 3'h0;
			oCnt <= 3'h0;
			nFrm <= 8'h00;
		end else if (smp) begin
			sh <= {sh[6:0], mosi};
			sCnt <= sCnt + 3'h1;
			if (sCnt == 3'h7) begin
				got <= {sh[6:0], mosi};
				nFrm <= nFrm + 8'h01;
			end
		end else if (edgeSeen) begin
			oCnt <= oCnt + 3'h1;
		end
	end
endmodule // usm_slave_model

// ### tb_usart_master_spi_mode.sv
// Self-checking bench for the master serial block with a slave model on its pins.
`timescale 1ns/100ps
`include "usm_regs.vh"
module tb_usart_master_spi_mode;
	reg clk_sys = 1'b0;
	reg nrst = 1'b0;
	reg [7:0] regAddr = 8'h00;
	reg [7:0] regWdata = 8'h00;
	reg regWrite = 1'b0;
	reg regRead = 1'b0;
	reg clockPinDirectionBit = 1'b1;
	reg restart = 1'b1;
	reg cpol = 1'b0;
	reg cpha = 1'b0;
	reg [7:0] base = 8'h00;
	reg [7:0] rv;
	reg [31:0] seed = 32'hdb51_d9f7;
	integer n_fail = 0;
	integer compares = 0;
	integer cyc = 0;
	integer k;
	wire [7:0] regRdata;
	wire [7:0] got;
	wire [7:0] nFrm;
	wire miso, mosi, sck, irqRx, irqTx, irqDe, outOe, clkOe;
	usm_master_spi dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .serialInPin(miso),
		.serialOutPin(mosi), .serialOutOe(outOe), .transferClockPin(sck), .transferClockOe(clkOe),
		.clockPinDirectionBit(clockPinDirectionBit), .irqRxComplete(irqRx),
		.irqTxComplete(irqTx), .irqDataEmpty(irqDe));
	usm_slave_model peer (.clk_sys(clk_sys), .restart(restart), .cpol(cpol), .cpha(cpha),
		.base(base), .sck(sck), .mosi(mosi), .miso(miso), .got(got), .nFrm(nFrm));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function [7:0] rev(input [7:0] v, input l);
		integer j;
		begin
			for (j = 0; j < 8; j = j + 1)
				rev[j] = l ? v[7 - j] : v[j];
		end
	endfunction
	task chk(input [95:0] what, input [7:0] e, input [7:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s exp %h got %h", what, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			regAddr <= a;
			regWdata <= d;
			regWrite <= 1'b1;
			@(posedge clk_sys);
			regWrite <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rd(input [7:0] a);
		begin
			regAddr <= a;
			regRead <= 1'b1;
			@(posedge clk_sys);
			regRead <= 1'b0;
			#1 rv = regRdata;
			@(posedge clk_sys);
		end
	endtask
	task waitIrq(input w);
		integer n;
		begin
			n = 0;
			@(negedge clk_sys);
			while ((w ? irqDe : irqTx) !== 1'b1 && n < 5000) begin
				@(negedge clk_sys);
				n = n + 1;
			end
			if (n >= 5000) chk("wait", 8'h01, 8'h00);
			@(posedge clk_sys);
		end
	endtask
	task run(input integer nb, input [1:0] md, input l, input [11:0] dv);
		integer i;
		integer e;
		integer t0;
		reg [7:0] tx;
		begin
			wr(`USM_ADDR_CTRL_C, {`USM_MODE_MASTER, 3'h0, l, md});
			cpol <= md[0];
			cpha <= md[1];
			base <= seed[7:0];
			restart <= 1'b1;
			wr(`USM_ADDR_BAUD_HI, {4'h0, dv[11:8]});
			restart <= 1'b0;
			wr(`USM_ADDR_BAUD_LO, dv[7:0]);
			wr(`USM_ADDR_STATUS_A, 8'h40);
			for (i = 0; i < nb; i = i + 1) begin
				waitIrq(1'b1);
				if (i == 0) t0 = cyc;
				seed = xs(seed);
				tx = seed[7:0];
				wr(`USM_ADDR_DATA, tx);
			end
			waitIrq(1'b0);
			e = cyc - t0 - nb * 16 * (dv + 1);
			chk("txc time", 8'h01, {7'h00, e >= 2 && e <= 7});
			for (i = 0; i < nb && i < 2; i = i + 1) begin
				rd(`USM_ADDR_DATA);
				if (dv > 3) chk("rx byte", rev(base + i[7:0], l), rv);
			end
			chk("rx left", 8'h00, {7'h00, irqRx});
			chk("peer byte", rev(tx, l), got);
			chk("frames", nb[7:0], nFrm);
			chk("sck idle", {7'h00, md[0]}, {7'h00, sck});
			chk("out idle", 8'h01, {7'h00, mosi});
			chk("out oe", 8'h01, {7'h00, outOe});
			chk("clk oe", 8'h01, {7'h00, clkOe});
		end
	endtask
	task give_verdict;
		begin
			$display("compares %0d mismatches %0d", compares, n_fail);
			if (n_fail == 0 && compares > 0) begin
				$display("TEST PASSED");
			end else begin
				$display("TEST FAILED");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_fail = n_fail + 1;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rd(`USM_ADDR_STATUS_A);
		chk("status rst", `USM_RST_STATUS_A, rv);
		rd(`USM_ADDR_CTRL_C);
		chk("ctrl c rst", `USM_RST_CTRL_C, rv);
		rd(`USM_ADDR_BAUD_LO);
		chk("baud lo rst", 8'h00, rv);
		rd(8'hC3);
		chk("unmapped", 8'h00, rv);
		wr(`USM_ADDR_BAUD_HI, 8'hFF);
		rd(`USM_ADDR_BAUD_HI);
		chk("baud hi", 8'h0F, rv);
		wr(`USM_ADDR_BAUD_HI, 8'h00);
		wr(`USM_ADDR_CTRL_C, 8'hC0);
		wr(`USM_ADDR_CTRL_B, 8'hF8);
		run(1, 2'h0, 1'b0, 12'h000);
		for (k = 0; k < 8; k = k + 1) begin
			seed = xs(seed);
			run(k % 3 + 1, k[1:0], k[2], 12'h004 + {10'h000, seed[9:8]});
		end
		for (k = 0; k < 2; k = k + 1) begin
			wr(`USM_ADDR_CTRL_C, k ? 8'hC0 : 8'h06);
			wr(`USM_ADDR_CTRL_B, k ? 8'hF0 : 8'hF8);
			restart <= 1'b1;
			wr(`USM_ADDR_DATA, 8'hA5);
			restart <= 1'b0;
			repeat (200) @(posedge clk_sys);
			chk("refused", 8'h00, nFrm);
			chk("rx none", 8'h00, {7'h00, irqRx});
			chk("oe off", {7'h00, k == 0}, {7'h00, outOe});
		end
		give_verdict;
	end
endmodule // tb_usart_master_spi_mode
